// *** bench/bci_line_model.sv ***
// Line interface model: sends its identity byte after the module turns ready.
// Assumes the ready indicator marks the start of synchronisation.
`timescale 1ns/1ps

module bci_line_model #(
	parameter [7:0] ID = 8'h5a, // Arbitrary value.
	parameter DLY = 3
) (
	input wire clk_i,
	input wire rstn_i,
	input wire go_i,
	input wire answer_i,
	output reg li_id_valid_o,
	output reg [7:0] li_id_o
);
	reg go_q;
	reg arm_q;
	reg [7:0] cnt_q;
	// Outside the strobe the byte lines change every cycle, so a stale identity cannot pass.
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			go_q <= 1'b0;
			arm_q <= 1'b0;
			cnt_q <= 8'h00;
			li_id_valid_o <= 1'b0;
			li_id_o <= 8'h00;
		end else begin
			go_q <= go_i;
			cnt_q <= cnt_q + 8'h01;
			li_id_valid_o <= 1'b0;
			li_id_o <= ~cnt_q;
			if (go_i && !go_q && answer_i) begin
				arm_q <= 1'b1;
				cnt_q <= 8'h00;
			end else if (arm_q && cnt_q == DLY) begin
				arm_q <= 1'b0;
				li_id_valid_o <= 1'b1;
				li_id_o <= ID;
			end
		end
	end
endmodule // bci_line_model

// *** bench/bci_properties.sv ***
// Port checker for the boot command interpreter top module.
// Assumes one clock domain and the shared constants header.
`timescale 1ns/1ps
`include "bci_consts.vh"

module bci_properties (
	input wire clk_i,
	input wire rstn_i,
	input wire [3:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire cmd_valid_i,
	input wire cmd_ready_o,
	input wire [31:0] cmd_tag_i,
	input wire [2:0] cmd_slot_i,
	input wire [7:0] command_code_i,
	input wire [15:0] cmd_offset_i,
	input wire [15:0] cmd_base_i,
	input wire reply_valid_o,
	input wire [31:0] request_tag_o,
	input wire [2:0] reply_slot_o,
	input wire [7:0] reply_type_o,
	input wire done_o,
	input wire [7:0] done_status_o,
	input wire mem_we_o,
	input wire [19:0] mem_addr_o,
	input wire ready_led_o,
	input wire host_alert_bit_o,
	input wire [3:0] module_state_o,
	input wire [15:0] instruction_pointer_reg_o,
	input wire [15:0] code_segment_o
);
	// ****************************************
	// Command and handshake properties
	// ****************************************
	// A slot 0 command taken on this edge, and a control register write.
	wire take0 = cmd_valid_i && cmd_ready_o && cmd_slot_i == `BCI_SLOT_SYS;
	wire ctrl_wr = reg_wr_i && reg_addr_i == `BCI_REG_CTRL;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_reset_retest: assert property (
		($rose(rstn_i) || ctrl_wr && reg_wdata_i[`BCI_CTRL_RESET]) |-> ##[0:2] module_state_o == `BCI_MS_TESTING)
		else $error("self-test not started after reset");
	a_ready_alert: assert property (
		$rose(ready_led_o) |-> module_state_o == `BCI_MS_READY && host_alert_bit_o)
		else $error("ready without state or host alert");
	a_alert_opens: assert property (
		ctrl_wr && reg_wdata_i[`BCI_CTRL_MA] && module_state_o == `BCI_MS_READY && !host_alert_bit_o
		|-> ##[1:3] cmd_ready_o) else $error("module alert did not open commands");
	a_status_reply: assert property (
		take0 && command_code_i == `BCI_CMD_STATUS |=> reply_valid_o && request_tag_o == $past(cmd_tag_i)
		##1 done_o && done_status_o == `BCI_ST_OK) else $error("status reply wrong");
	a_reply_head: assert property (
		reply_valid_o |-> reply_slot_o == `BCI_SLOT_SYS && reply_type_o == `BCI_MSG_STATUS)
		else $error("reply slot or type wrong");
	a_bad_code: assert property (
		take0 && command_code_i != `BCI_CMD_LOAD && command_code_i != `BCI_CMD_JUMP
		&& command_code_i != `BCI_CMD_STATUS |=> !reply_valid_o && !mem_we_o
		##1 done_o && done_status_o != `BCI_ST_OK) else $error("unknown code not refused");
	a_jump_regs: assert property (
		take0 && command_code_i == `BCI_CMD_JUMP |-> ##2 done_o && instruction_pointer_reg_o == $past(cmd_offset_i, 2)
		&& code_segment_o == $past(cmd_base_i, 2)) else $error("jump registers wrong");
	a_load_step: assert property (
		mem_we_o && $past(mem_we_o) |-> mem_addr_o == $past(mem_addr_o) + 20'h1)
		else $error("load address did not step by one");
endmodule // bci_properties

// *** bench/bci_top_tb.sv ***
// Testbench for the boot command interpreter: handshake, slot 0 commands, status replies.
// Assumes the line model answers within the shortened line timeout.
`timescale 1ns/1ps
`include "bci_consts.vh"

module bci_top_tb;
	localparam [15:0] BOOT_V = 16'h0103, CODE_V = 16'h0207, F_ST = 16'h0020, F_LN = 16'h0040;
	localparam [7:0] LI_ID = 8'h5a; // Arbitrary value.
	logic clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, test_fail_i = 0, cmd_valid_i = 0;
	logic data_valid_i = 0, li_present_i = 1, answer = 1, rv = 0;
	logic [3:0] reg_addr_i = 0;
	logic [31:0] reg_wdata_i = 0, test_detail_i = 0, cmd_tag_i = 0, v;
	logic [2:0] cmd_slot_i = 0;
	logic [7:0] command_code_i = 0, data_i = 0, slot_present_i = 8'h03, st;
	logic [15:0] cmd_offset_i = 0, cmd_base_i = 0, cmd_used_i = 0, last_marker_i = 16'h0055;
	logic [19:0] ea = 0;
	wire li_id_valid_i, data_ready_o, cmd_ready_o, done_o, reply_valid_o, ready_led_o, host_alert_bit_o;
	wire code_running_o, mem_we_o, li_enable_o;
	wire [7:0] li_id_i, done_status_o, reply_type_o, reply_status_o, mem_wdata_o;
	wire [31:0] reg_rdata_o, request_tag_o;
	wire [2:0] reply_slot_o;
	wire [3:0] module_state_o;
	wire [15:0] firmware_version_field_o, line_interface_id_field_o, last_marker_o, free_memory_start_o;
	wire [15:0] free_memory_length_o, instruction_pointer_reg_o, code_segment_o;
	wire [19:0] mem_addr_o;
	integer err_total = 0, checked = 0, nw = 0, k;

	always #12.5 clk_i = ~clk_i;

	bci_top #(.TEST_CYC(4), .LI_TIMEOUT(16'd8), .BOOT_VERSION(BOOT_V), .CODE_VERSION(CODE_V),
		.FREE_START(F_ST), .FREE_LENGTH(F_LN)) u_dut (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .test_fail_i, .test_detail_i, .cmd_valid_i, .cmd_tag_i,
		.cmd_slot_i, .command_code_i, .cmd_offset_i, .cmd_base_i, .cmd_used_i, .data_valid_i, .data_i,
		.data_ready_o, .slot_present_i, .last_marker_i, .cmd_ready_o, .done_o, .done_status_o,
		.reply_valid_o, .request_tag_o, .reply_slot_o, .reply_type_o, .reply_status_o,
		.firmware_version_field_o, .line_interface_id_field_o, .last_marker_o, .free_memory_start_o,
		.free_memory_length_o, .ready_led_o, .host_alert_bit_o, .module_state_o, .code_running_o,
		.instruction_pointer_reg_o, .code_segment_o, .mem_addr_o, .mem_we_o, .mem_wdata_o,
		.li_present_i, .li_id_valid_i, .li_id_i, .li_enable_o);
	bci_line_model #(.ID(LI_ID)) u_line (.clk_i, .rstn_i, .go_i(ready_led_o), .answer_i(answer),
		.li_id_valid_o(li_id_valid_i), .li_id_o(li_id_i));

	// ****************************************
	// Access tasks and comparison
	// ****************************************
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task complete_run;
		begin
			if (err_total == 0 && checked > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			reg_wr_i <= 1;
			reg_addr_i <= a;
			reg_wdata_i <= d;
			@(posedge clk_i);
			reg_wr_i <= 0;
		end
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken at the closing edge.
	task rd(input [3:0] a, output [31:0] d);
		begin
			@(posedge clk_i);
			reg_rd_i <= 1;
			reg_addr_i <= a;
			@(posedge clk_i);
			reg_rd_i <= 0;
			@(posedge clk_i);
			d = reg_rdata_o;
		end
	endtask
	task wait_state(input [3:0] s);
		integer i;
		begin
			for (i = 0; i < 200 && module_state_o !== s; i = i + 1)
				@(posedge clk_i);
			chk(module_state_o, s);
		end
	endtask
	// Load bytes go two back to back, then one after a gap, to exercise both paths.
	task cmd(input [31:0] tag, input [2:0] sl, input [7:0] op, input [15:0] off, input [15:0] base,
		input [15:0] used);
		integer i, n;
		logic dn;
		begin
			i = 0;
			n = 0;
			dn = 0;
			rv = 0;
			@(posedge clk_i);
			while (cmd_ready_o !== 1'b1 && i < 60) begin
				@(posedge clk_i);
				i = i + 1;
			end
			cmd_valid_i <= 1;
			cmd_tag_i <= tag;
			cmd_slot_i <= sl;
			command_code_i <= op;
			cmd_offset_i <= off;
			cmd_base_i <= base;
			cmd_used_i <= used;
			for (i = 0; i < 60 && !dn; i = i + 1) begin
				@(posedge clk_i);
				cmd_valid_i <= 0;
				if (reply_valid_o === 1'b1)
					rv = 1;
				if (done_o === 1'b1) begin
					dn = 1;
					st = done_status_o;
				end
				// One assignment per edge keeps the byte strobe free of same-step overwrites.
				data_valid_i <= !dn && op == 0 && i > 0 && i != 3 && n < used;
				if (!dn && op == 0 && i > 0 && i != 3 && n < used) begin
					data_i <= 8'ha0 + n[7:0];
					n = n + 1;
				end
			end
			chk(dn, 1);
		end
	endtask
	task status(input [15:0] ver, input [15:0] mk, input [15:0] fs, input [15:0] fl);
		begin
			cmd({16'hc0de, ver}, 3'h0, `BCI_CMD_STATUS, 16'h0, 16'h0, 16'h0);
			chk({rv, st, reply_status_o}, {1'b1, 16'h0});
			chk(request_tag_o, {16'hc0de, ver});
			chk({reply_slot_o, reply_type_o}, {3'h0, 8'h04});
			chk({firmware_version_field_o, line_interface_id_field_o}, {ver, 8'h00, LI_ID});
			chk({last_marker_o, free_memory_start_o}, {mk, fs});
			chk(free_memory_length_o, fl);
			chk(host_alert_bit_o, 1);
			wr(`BCI_REG_CTRL, 32'h105);
		end
	endtask

	// Each memory write must land on the next address of the load with the next byte.
	always @(posedge clk_i) begin
		if (mem_we_o === 1'b1) begin
			chk(mem_addr_o, ea);
			chk(mem_wdata_o, 8'ha0 + nw);
			ea = ea + 20'h1;
			nw = nw + 1;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk_i);
		rstn_i <= 1;
		wait_state(`BCI_MS_READY);
		chk({ready_led_o, host_alert_bit_o}, 2'b11);
		repeat (16) @(posedge clk_i);
		rd(`BCI_REG_LIID, v);
		chk(v, {24'h0, LI_ID});
		chk(li_enable_o, 1);
		// Host acknowledges, opens memory in bank 1, then raises the module alert.
		wr(`BCI_REG_CTRL, 32'h105);
		wr(`BCI_REG_CTRL, 32'h106);
		rd(`BCI_REG_CTRL, v);
		chk(v[1], 0);
		status(BOOT_V, 16'h0, F_ST, F_LN);
		ea = 20'h00123;
		cmd(32'h1, 3'h0, `BCI_CMD_LOAD, 16'h0003, 16'h0012, 16'h3);
		chk({nw[7:0], st}, 16'h0300);
		chk({cmd_ready_o, data_ready_o}, 2'b10);
		for (k = 0; k < 4; k = k + 1) begin
			cmd(32'h2, 3'h0, 8'h02 + 8'h03 * k[7:0], 16'h0, 16'h0, 16'h1);
			chk({rv, st != 8'h00}, 2'b01);
		end
		chk(nw, 3);
		cmd(32'h3, 3'h3, `BCI_CMD_STATUS, 16'h0, 16'h0, 16'h0);
		chk({rv, st != 8'h00}, 2'b01);
		cmd(32'h5, 3'h1, 8'h00, 16'h0, 16'h0, 16'h0);
		chk({rv, st, nw[7:0]}, 17'h00003);
		cmd(32'h4, 3'h0, `BCI_CMD_JUMP, 16'h0040, 16'h0012, 16'h0);
		chk({instruction_pointer_reg_o, code_segment_o}, 32'h0040_0012);
		chk({code_running_o, st}, 9'h100);
		rd(`BCI_REG_CSIP, v);
		chk(v, 32'h0012_0040);
		rd(`BCI_REG_STAT, v);
		chk(v, 32'h0000_0113);
		rd(`BCI_REG_VERS, v);
		chk(v, {16'h0, CODE_V});
		rd(`BCI_REG_FREE, v);
		chk(v, {F_LN, F_ST});
		status(CODE_V, 16'h0055, 16'h0, 16'h0);
		rd(4'hf, v);
		chk(v, 0);
		// Register reset with a silent line interface.
		answer <= 0;
		wr(`BCI_REG_CTRL, 32'h8);
		wait_state(`BCI_MS_TESTING);
		wait_state(`BCI_MS_READY);
		repeat (16) @(posedge clk_i);
		rd(`BCI_REG_LIID, v);
		chk({li_enable_o, v[30:0]}, 32'h0200);
		// A missing line interface reports not installed and stays disabled.
		li_present_i <= 0;
		wr(`BCI_REG_CTRL, 32'h8);
		wait_state(`BCI_MS_TESTING);
		wait_state(`BCI_MS_READY);
		repeat (4) @(posedge clk_i);
		rd(`BCI_REG_LIID, v);
		chk({li_enable_o, v[30:0]}, 32'h0100);
		// A failing self-test leaves the error code and its detail word.
		test_fail_i <= 1;
		test_detail_i <= 32'h1234_abcd;
		wr(`BCI_REG_CTRL, 32'h8);
		wait_state(`BCI_MS_ERROR);
		rd(`BCI_REG_ERRD, v);
		chk(v, 32'h1234_abcd);
		complete_run;
	end

	// The run needs under two hundred cycles; this cuts a hang short well beyond that.
	initial begin
		#200000;
		err_total = err_total + 1;
		complete_run;
	end
endmodule // bci_top_tb

bind bci_top bci_properties u_chk (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .cmd_valid_i,
	.cmd_ready_o, .cmd_tag_i, .cmd_slot_i, .command_code_i, .cmd_offset_i, .cmd_base_i, .reply_valid_o,
	.request_tag_o, .reply_slot_o, .reply_type_o, .done_o, .done_status_o, .mem_we_o, .mem_addr_o,
	.ready_led_o, .host_alert_bit_o, .module_state_o, .instruction_pointer_reg_o, .code_segment_o);

// *** src/bci_consts.vh ***
// Constants for the boot command interpreter: command codes, reply fields,
// module state codes, line-interface outcomes and its hidden register map.
// Assumes inclusion by bare name from the design files of the block that use its constants.
`ifndef BCI_CONSTS_VH
`define BCI_CONSTS_VH

// Slot 0 command codes.
`define BCI_CMD_LOAD 8'h00
`define BCI_CMD_JUMP 8'h01
`define BCI_CMD_STATUS 8'h04
`define BCI_SLOT_SYS 3'h0

// Reply message type for a status reply.
`define BCI_MSG_STATUS 8'h04

// Command completion status codes.
`define BCI_ST_OK 8'h00
`define BCI_ST_BAD_SLOT 8'h01
`define BCI_ST_BAD_CODE 8'h02

// Module state field codes.
`define BCI_MS_RESET 4'h0
`define BCI_MS_TESTING 4'h1
`define BCI_MS_READY 4'h2
`define BCI_MS_RUNNING 4'h3
`define BCI_MS_ERROR 4'h8

// Line interface condition codes, upper byte of the identity field.
`define BCI_LI_NORMAL 8'h00
`define BCI_LI_ABSENT 8'h01
`define BCI_LI_BROKEN 8'h02

// Physical address is base shifted by this many bits plus the offset.
`define BCI_PARA_SHIFT 4

// Register word addresses.
`define BCI_REG_CTRL 4'h0
`define BCI_REG_STAT 4'h1
`define BCI_REG_VERS 4'h2
`define BCI_REG_LIID 4'h3
`define BCI_REG_MARK 4'h4
`define BCI_REG_FREE 4'h5
`define BCI_REG_CSIP 4'h6
`define BCI_REG_ERRD 4'h7

// Control register bit positions.
`define BCI_CTRL_HA 0
`define BCI_CTRL_MA 1
`define BCI_CTRL_MEMEN 2
`define BCI_CTRL_RESET 3
`define BCI_CTRL_BANK_LO 8

// Self-test length in microseconds and its cycle count at 40 MHz.
`define BCI_TEST_US 10
`define BCI_CLK_MHZ 40
`define BCI_TEST_CYC (`BCI_TEST_US * `BCI_CLK_MHZ)

`endif

// *** src/bci_line_sync.v ***
// Line interface synchroniser: waits for the identity byte after a restart.
// Assumes the identity strobe is synchronous to clk_i.
`timescale 1ns/1ps
`include "bci_consts.vh"

module bci_line_sync #(
	parameter TIMEOUT = 16'd4000
) (
	input wire clk_i,
	input wire rstn_i,
	input wire start_i,
	input wire present_i,
	input wire id_valid_i,
	input wire [7:0] id_i,
	output reg enable_o,
	output reg done_o,
	output reg [15:0] id_field_o
);

	reg [15:0] cnt_q;
	reg busy_q;

	// A silent interface is disabled and stays so until the next start.
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 16'h0000;
			busy_q <= 1'b0;
			enable_o <= 1'b0;
			done_o <= 1'b0;
			id_field_o <= {`BCI_LI_ABSENT, 8'h00};
		end else if (start_i) begin
			cnt_q <= 16'h0000;
			busy_q <= 1'b1;
			enable_o <= 1'b0;
			done_o <= 1'b0;
		end else if (busy_q) begin
			if (!present_i) begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
				id_field_o <= {`BCI_LI_ABSENT, 8'h00};
			end else if (id_valid_i) begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
				id_field_o <= {`BCI_LI_NORMAL, id_i};
				enable_o <= 1'b1;
			end else if (cnt_q == TIMEOUT) begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
				id_field_o <= {`BCI_LI_BROKEN, 8'h00};
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

endmodule // bci_line_sync

// *** src/bci_mem.v ***
// Private module memory written by the block loader and read back by software.
// Assumes one clock; read data appear from a register one cycle after the address.
`timescale 1ns/1ps

module bci_mem #(
	parameter AW = 10
) (
	input wire clk_i,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [7:0] wdata_i,
	input wire [AW-1:0] raddr_i,
	output reg [7:0] rdata_o
);

	reg [7:0] mem_q [0:(1<<AW)-1];

	// Write port and registered read port; no reset, contents are undefined.
	always @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_q[raddr_i];
	end

endmodule // bci_mem

// *** src/bci_top.v ***
// Boot command interpreter: power-up handshake, slot 0 commands, status replies.
// Assumes commands arrive one at a time from a ring engine with a valid strobe,
// and that reply and completion strobes are taken by that engine without wait.
`timescale 1ns/1ps
`include "bci_consts.vh"

// What this block does
// - Each reply carries the command's tag word unchanged.
// - Each reply carries the slot of its command.
// - Any reset starts initialisation and self-test automatically.
// - Failed self-test writes error state and detail word.
// - Passed self-test writes ready, lights indicator, sets host alert, waits.
// - Device clears module alert before processing commands.
// - Code 0 copies data bytes to memory at base and offset.
// - Physical address is sixteen times base plus offset.
// - Only the offset advances per byte during a load.
// - Code 1 loads offset into pointer and base into segment.
// - Code 4 returns a status reply.
// - Status reply has slot 0 and type 4.
// - Version field holds major high byte, minor low byte.
// - Line identity field holds condition high, identity code low.
// - Marker field is 0 from boot firmware, else last marker.
// - Free start is first free paragraph from boot firmware, else 0.
// - Free length is free paragraph count from boot firmware, else 0.
// - Failed line synchronisation disables the interface until restart.
// - Successful synchronisation records identity and enables interface in the same cycle.
// - Status zero on success, nonzero on error.
// - Command to an empty slot returns error status.
// - Host alert set on every state change or ring movement.
module bci_top #(
	parameter AW = 10,
	parameter TEST_CYC = `BCI_TEST_CYC,
	parameter LI_TIMEOUT = 16'd4000,
	parameter [15:0] BOOT_VERSION = 16'h0100, // Arbitrary value.
	parameter [15:0] CODE_VERSION = 16'h0200, // Arbitrary value.
	parameter [15:0] FREE_START = 16'h0010,
	parameter [15:0] FREE_LENGTH = 16'h0030
) (
	input wire clk_i,
	input wire rstn_i,
	// Register port.
	input wire [3:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// Self-test result.
	input wire test_fail_i,
	input wire [31:0] test_detail_i,
	// Command from the command ring.
	input wire cmd_valid_i,
	input wire [31:0] cmd_tag_i,
	input wire [2:0] cmd_slot_i,
	input wire [7:0] command_code_i,
	input wire [15:0] cmd_offset_i,
	input wire [15:0] cmd_base_i,
	input wire [15:0] cmd_used_i,
	input wire data_valid_i,
	input wire [7:0] data_i,
	output wire data_ready_o,
	input wire [7:0] slot_present_i,
	input wire [15:0] last_marker_i,
	output wire cmd_ready_o,
	output reg done_o,
	output reg [7:0] done_status_o,
	// Reply toward the message ring.
	output reg reply_valid_o,
	output reg [31:0] request_tag_o,
	output reg [2:0] reply_slot_o,
	output reg [7:0] reply_type_o,
	output reg [7:0] reply_status_o,
	output reg [15:0] firmware_version_field_o,
	output reg [15:0] line_interface_id_field_o,
	output reg [15:0] last_marker_o,
	output reg [15:0] free_memory_start_o,
	output reg [15:0] free_memory_length_o,
	// Status pins.
	output reg ready_led_o,
	output reg host_alert_bit_o,
	output reg [3:0] module_state_o,
	output reg code_running_o,
	output reg [15:0] instruction_pointer_reg_o,
	output reg [15:0] code_segment_o,
	output reg [19:0] mem_addr_o,
	output reg mem_we_o,
	output reg [7:0] mem_wdata_o,
	// Line interface.
	input wire li_present_i,
	input wire li_id_valid_i,
	input wire [7:0] li_id_i,
	output wire li_enable_o
);

	// ****************************************
	// State codes and helpers
	// ****************************************
	localparam [6:0] S_TEST = 7'b0000001;
	localparam [6:0] S_WAIT_HA = 7'b0000010;
	localparam [6:0] S_WAIT_MA = 7'b0000100;
	localparam [6:0] S_IDLE = 7'b0001000;
	localparam [6:0] S_LOAD = 7'b0010000;
	localparam [6:0] S_DONE = 7'b0100000;
	localparam [6:0] S_FAIL = 7'b1000000;

	// Segment arithmetic shared by loader and jump.
	function [19:0] phys_addr;
		input [15:0] base;
		input [15:0] off;
		begin
			phys_addr = ({4'h0, base} << `BCI_PARA_SHIFT) + {4'h0, off};
		end
	endfunction

	reg [6:0] state_q;
	reg [31:0] test_cnt_q;
	reg ma_q;
	reg memen_q;
	reg [3:0] bank_q;
	reg soft_rst_q;
	reg [31:0] err_detail_q;
	reg [15:0] load_off_q;
	reg [15:0] load_base_q;
	reg [15:0] load_left_q;
	reg [7:0] load_status_q;
	reg li_start_q;
	wire li_done;
	wire [15:0] li_field;
	wire [7:0] mem_rdata;
	wire ha_clear;
	wire ma_set;
	wire ctl_wr;

	assign ctl_wr = reg_wr_i && (reg_addr_i == `BCI_REG_CTRL);
	// Host clears host alert by writing a one, sets module alert the same way.
	assign ha_clear = ctl_wr && reg_wdata_i[`BCI_CTRL_HA];
	assign ma_set = ctl_wr && reg_wdata_i[`BCI_CTRL_MA];
	assign cmd_ready_o = (state_q == S_IDLE);
	assign data_ready_o = (state_q == S_LOAD);

	// ****************************************
	// Submodules
	// ****************************************
	bci_mem #(.AW(AW)) u_mem (
		.clk_i(clk_i),
		.we_i(mem_we_o),
		.waddr_i(mem_addr_o[AW-1:0]),
		.wdata_i(mem_wdata_o),
		.raddr_i(reg_wdata_i[AW-1:0]),
		.rdata_o(mem_rdata)
	);

	bci_line_sync #(.TIMEOUT(LI_TIMEOUT)) u_line (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.start_i(li_start_q),
		.present_i(li_present_i),
		.id_valid_i(li_id_valid_i),
		.id_i(li_id_i),
		.enable_o(li_enable_o),
		.done_o(li_done),
		.id_field_o(li_field)
	);

	// ****************************************
	// Control register
	// ****************************************
	// Memory enable, bank and the soft reset request come from software.
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			memen_q <= 1'b0;
			bank_q <= 4'h0;
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= ctl_wr && reg_wdata_i[`BCI_CTRL_RESET];
			if (ctl_wr) begin
				memen_q <= reg_wdata_i[`BCI_CTRL_MEMEN];
				bank_q <= reg_wdata_i[`BCI_CTRL_BANK_LO+3:`BCI_CTRL_BANK_LO];
			end
		end
	end

	// ****************************************
	// Main sequencer
	// ****************************************
	// Host alert setting wins over a host clear in the same cycle so no event is lost.
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= S_TEST;
			test_cnt_q <= 32'h0;
			module_state_o <= `BCI_MS_TESTING;
			host_alert_bit_o <= 1'b0;
			ma_q <= 1'b0;
			ready_led_o <= 1'b0;
			err_detail_q <= 32'h0;
			code_running_o <= 1'b0;
			instruction_pointer_reg_o <= 16'h0;
			code_segment_o <= 16'h0;
			load_off_q <= 16'h0;
			load_base_q <= 16'h0;
			load_left_q <= 16'h0;
			load_status_q <= `BCI_ST_OK;
			li_start_q <= 1'b0;
			done_o <= 1'b0;
			done_status_o <= `BCI_ST_OK;
			reply_valid_o <= 1'b0;
			request_tag_o <= 32'h0;
			reply_slot_o <= 3'h0;
			reply_type_o <= 8'h0;
			reply_status_o <= 8'h0;
			firmware_version_field_o <= 16'h0;
			line_interface_id_field_o <= 16'h0;
			last_marker_o <= 16'h0;
			free_memory_start_o <= 16'h0;
			free_memory_length_o <= 16'h0;
			mem_addr_o <= 20'h0;
			mem_we_o <= 1'b0;
			mem_wdata_o <= 8'h0;
		end else if (soft_rst_q) begin
			// Register reset restarts self-test; line synchronisation restarts only once that self-test passes.
			state_q <= S_TEST;
			test_cnt_q <= 32'h0;
			module_state_o <= `BCI_MS_TESTING;
			host_alert_bit_o <= 1'b1;
			ma_q <= 1'b0;
			ready_led_o <= 1'b0;
			code_running_o <= 1'b0;
			done_o <= 1'b0;
			reply_valid_o <= 1'b0;
			mem_we_o <= 1'b0;
			li_start_q <= 1'b0;
		end else begin
			done_o <= 1'b0;
			reply_valid_o <= 1'b0;
			mem_we_o <= 1'b0;
			li_start_q <= 1'b0;
			if (ma_set) begin
				ma_q <= 1'b1;
			end
			if (ha_clear) begin
				host_alert_bit_o <= 1'b0;
			end
			case (state_q)
				S_TEST: begin
					if (test_cnt_q == TEST_CYC - 1) begin
						if (test_fail_i) begin
							state_q <= S_FAIL;
							module_state_o <= `BCI_MS_ERROR;
							err_detail_q <= test_detail_i;
						end else begin
							state_q <= S_WAIT_HA;
							module_state_o <= `BCI_MS_READY;
							ready_led_o <= 1'b1;
							li_start_q <= 1'b1;
						end
						host_alert_bit_o <= 1'b1;
					end else begin
						test_cnt_q <= test_cnt_q + 32'h1;
					end
				end
				S_WAIT_HA: begin
					if (ha_clear) begin
						state_q <= S_WAIT_MA;
					end
				end
				S_WAIT_MA: begin
					if (ma_q || ma_set) begin
						ma_q <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				S_IDLE: begin
					if (cmd_valid_i) begin
						request_tag_o <= cmd_tag_i;
						reply_slot_o <= cmd_slot_i;
						if (!slot_present_i[cmd_slot_i] && cmd_slot_i != `BCI_SLOT_SYS) begin
							done_status_o <= `BCI_ST_BAD_SLOT;
							state_q <= S_DONE;
						end else if (cmd_slot_i != `BCI_SLOT_SYS) begin
							done_status_o <= `BCI_ST_OK;
							state_q <= S_DONE;
						end else if (command_code_i == `BCI_CMD_LOAD) begin
							load_off_q <= cmd_offset_i;
							load_base_q <= cmd_base_i;
							load_left_q <= cmd_used_i;
							load_status_q <= memen_q ? `BCI_ST_OK : `BCI_ST_BAD_CODE;
							state_q <= (cmd_used_i == 16'h0) ? S_DONE : S_LOAD;
							done_status_o <= `BCI_ST_OK;
						end else if (command_code_i == `BCI_CMD_JUMP) begin
							instruction_pointer_reg_o <= cmd_offset_i;
							code_segment_o <= cmd_base_i;
							mem_addr_o <= phys_addr(cmd_base_i, cmd_offset_i);
							code_running_o <= 1'b1;
							module_state_o <= `BCI_MS_RUNNING;
							done_status_o <= `BCI_ST_OK;
							state_q <= S_DONE;
						end else if (command_code_i == `BCI_CMD_STATUS) begin
							reply_valid_o <= 1'b1;
							reply_type_o <= `BCI_MSG_STATUS;
							reply_status_o <= `BCI_ST_OK;
							firmware_version_field_o <= code_running_o ? CODE_VERSION : BOOT_VERSION;
							line_interface_id_field_o <= li_field;
							last_marker_o <= code_running_o ? last_marker_i : 16'h0;
							free_memory_start_o <= code_running_o ? 16'h0 : FREE_START;
							free_memory_length_o <= code_running_o ? 16'h0 : FREE_LENGTH;
							host_alert_bit_o <= 1'b1;
							done_status_o <= `BCI_ST_OK;
							state_q <= S_DONE;
						end else begin
							done_status_o <= `BCI_ST_BAD_CODE;
							state_q <= S_DONE;
						end
					end
				end
				S_LOAD: begin
					if (data_valid_i) begin
						mem_addr_o <= phys_addr(load_base_q, load_off_q);
						mem_wdata_o <= data_i;
						mem_we_o <= memen_q;
						load_off_q <= load_off_q + 16'h1;
						load_left_q <= load_left_q - 16'h1;
						if (load_left_q == 16'h1) begin
							done_status_o <= load_status_q;
							state_q <= S_DONE;
						end
					end
				end
				S_DONE: begin
					done_o <= 1'b1;
					host_alert_bit_o <= 1'b1;
					state_q <= S_IDLE;
				end
				S_FAIL: begin
					state_q <= S_FAIL;
				end
				default: begin
					state_q <= S_TEST;
				end
			endcase
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	// Read data stand only in the cycle after the strobe; unmapped reads give zero.
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 32'h0;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_addr_i == `BCI_REG_CTRL) begin
			reg_rdata_o <= {20'h0, bank_q, 4'h0, 1'b0, memen_q, ma_q, host_alert_bit_o};
		end else if (reg_addr_i == `BCI_REG_STAT) begin
			reg_rdata_o <= {16'h0, 7'h0, li_done, 3'h0, code_running_o, module_state_o};
		end else if (reg_addr_i == `BCI_REG_VERS) begin
			reg_rdata_o <= {16'h0, code_running_o ? CODE_VERSION : BOOT_VERSION};
		end else if (reg_addr_i == `BCI_REG_LIID) begin
			reg_rdata_o <= {16'h0, li_field};
		end else if (reg_addr_i == `BCI_REG_MARK) begin
			reg_rdata_o <= {24'h0, mem_rdata};
		end else if (reg_addr_i == `BCI_REG_FREE) begin
			reg_rdata_o <= {FREE_LENGTH, FREE_START};
		end else if (reg_addr_i == `BCI_REG_CSIP) begin
			reg_rdata_o <= {code_segment_o, instruction_pointer_reg_o};
		end else if (reg_addr_i == `BCI_REG_ERRD) begin
			reg_rdata_o <= err_detail_q;
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

endmodule // bci_top
